// ==== hbrr_top.sv ====
// host bridge request router: decode, translation, snoop choice and arbitration
`default_nettype none

module hbrr_top #(
    parameter int GFX_QDEPTH = hbrr_pkg::HBRR_GFX_QDEPTH,
    parameter int GTT_N = hbrr_pkg::HBRR_GTT_N
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cpu_ads_n_in,
    input wire logic [hbrr_pkg::HBRR_ADDR_W-1:0] cpu_addr_n_in,
    input wire logic cpu_io_in,
    input wire logic cpu_wr_in,
    output logic host_busy_out,
    input wire hbrr_pkg::hbrr_win_s cfg_io_win_in,
    input wire hbrr_pkg::hbrr_win_s gfx_io_win_in,
    input wire hbrr_pkg::hbrr_win_s gfx_mem_win_in,
    input wire hbrr_pkg::hbrr_win_s aper_win_in,
    input wire logic [hbrr_pkg::HBRR_ADDR_W-1:0] dram_top_in,
    input wire logic gtt_wr_in,
    input wire logic [$clog2(GTT_N)-1:0] gtt_idx_in,
    input wire logic [hbrr_pkg::HBRR_GTT_PW-1:0] gtt_page_in,
    input wire logic [hbrr_pkg::HBRR_NASYNC-1:0] port_req_in,
    input wire hbrr_pkg::hbrr_inb_s [hbrr_pkg::HBRR_NASYNC-1:0] port_attr_in,
    output logic [hbrr_pkg::HBRR_NASYNC-1:0] port_ack_out,
    input wire logic gfx_done_in,
    output logic [$clog2(GFX_QDEPTH+1)-1:0] gfx_qcnt_out,
    output logic gfx_full_out,
    input wire logic dram_ref_req_in,
    output logic ref_go_out,
    input wire logic strap_pipe_in,
    input wire logic strap_sba_in,
    input wire logic [2:0] strap_ratio_in,
    output logic pipe_en_out,
    output logic sba_en_out,
    output logic mode_err_out,
    output hbrr_pkg::hbrr_ratio_s ratio_out,
    output hbrr_pkg::hbrr_route_s route_out,
    output hbrr_pkg::hbrr_fwd_s fwd_out,
    output logic drop_out,
    output logic snoop_out,
    output logic [hbrr_pkg::HBRR_ADDR_W-1:0] snoop_addr_n_out,
    input wire logic pg_open_in,
    input wire logic pg_close_in,
    input wire logic [hbrr_pkg::HBRR_ADDR_W-1:0] pg_addr_in,
    output logic page_hit_out,
    output logic [$clog2(hbrr_pkg::HBRR_MAX_OPEN+1)-1:0] open_cnt_out
);
    import hbrr_pkg::*;

    localparam int QCW = $clog2(GFX_QDEPTH+1);
    localparam int OCW = $clog2(HBRR_MAX_OPEN+1);
    localparam int GW = $clog2(GTT_N);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [HBRR_NASYNC-1:0] ps1;
        logic [HBRR_NASYNC-1:0] ps2;
        logic [HBRR_NASYNC-1:0] ack;
        logic [4:0] st1;
        logic [4:0] st2;
        logic [1:0] init_cnt;
        logic init_done;
        logic h_pend;
        logic h_io;
        logic h_wr;
        logic [HBRR_ADDR_W-1:0] h_addr;
        logic [GTT_N-1:0][HBRR_GTT_PW-1:0] gtt;
        logic [HBRR_NRANK-1:0][HBRR_NBANK-1:0] pg_vld;
        logic [HBRR_NRANK-1:0][HBRR_NBANK-1:0][HBRR_ROW_W-1:0] pg_row;
        logic [QCW-1:0] gfx_cnt;
        logic gfx_full;
        hbrr_route_s route;
        hbrr_fwd_s fwd;
        logic drop;
        logic snoop;
        logic [HBRR_ADDR_W-1:0] snoop_addr_n;
        logic ref_go;
        logic pipe_en;
        logic sba_en;
        logic mode_err;
        hbrr_ratio_s ratio;
        logic page_hit;
        logic [OCW-1:0] open_cnt;
    } hbrr_top_st_s;

    hbrr_top_st_s s_q;
    hbrr_top_st_s s_d;

    logic [HBRR_NPORT-1:0] arb_req;
    logic [HBRR_NPORT-1:0] arb_hp;
    logic [HBRR_NPORT-1:0] arb_gnt;
    logic gfx_full;
    logic aper_hit;
    logic [HBRR_ADDR_W-1:0] aper_off;
    logic [HBRR_ADDR_W-1:0] xlat_addr;

    // ****************************************************************
    // aperture translation and arbitration
    // ****************************************************************
    assign aper_hit = hbrr_in_win(aper_win_in, s_q.h_addr);
    assign aper_off = s_q.h_addr - aper_win_in.base;
    assign xlat_addr = {s_q.gtt[aper_off[HBRR_PG_SHIFT +: GW]], s_q.h_addr[HBRR_PG_SHIFT-1:0]};
    assign gfx_full = s_q.gfx_full;

    // granted slots drop out for a cycle so one request is never granted twice
    assign arb_req = {dram_ref_req_in, s_q.ps2 & ~s_q.ack & {2'h3, ~gfx_full}, s_q.h_pend} & ~arb_gnt;
    assign arb_hp = {3'h0, port_attr_in[0].hi_pri, 1'b0};

    hbrr_arb #(
        .N(HBRR_NPORT)
    ) u_arb (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .req_in(arb_req),
        .hp_in(arb_hp),
        .gnt_out(arb_gnt)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        hbrr_inb_s a;
        hbrr_pgloc_s pl;
        hbrr_pgloc_s ol;
        logic [OCW-1:0] cnt;
        a = '0;
        pl = '0;
        ol = '0;
        cnt = '0;
        s_d = s_q;
        s_d.route.valid = 1'b0;
        s_d.fwd.valid = 1'b0;
        s_d.drop = 1'b0;
        s_d.snoop = 1'b0;
        s_d.ref_go = 1'b0;

        // 66 MHz port requests and straps come from outside this clock
        s_d.ps1 = port_req_in;
        s_d.ps2 = s_q.ps1;
        s_d.st1 = {strap_pipe_in, strap_sba_in, strap_ratio_in};
        s_d.st2 = s_q.st1;
        s_d.ack = s_q.ack & s_q.ps2;

        // straps latched once, after the synchronisers have settled
        if (!s_q.init_done)
        begin
            s_d.init_cnt = s_q.init_cnt + 2'h1;
            if (s_q.init_cnt == HBRR_STRAP_WAIT)
            begin
                s_d.init_done = 1'b1;
                s_d.pipe_en = s_q.st2[4];
                s_d.sba_en = s_q.st2[3] & ~s_q.st2[4];
                s_d.mode_err = ~(s_q.st2[4] ^ s_q.st2[3]);
                s_d.ratio = hbrr_ratio_f(s_q.st2[2:0]);
            end
        end

        if (gtt_wr_in)
        begin
            s_d.gtt[gtt_idx_in] = gtt_page_in;
        end

        // host cycle decode
        if (arb_gnt[HBRR_P_HOST])
        begin
            s_d.h_pend = 1'b0;
            s_d.route.valid = 1'b1;
            s_d.route.is_io = s_q.h_io;
            s_d.route.is_write = s_q.h_wr;
            s_d.route.addr = s_q.h_addr;
            if (s_q.h_io)
            begin
                if (hbrr_in_win(cfg_io_win_in, s_q.h_addr))
                begin
                    s_d.route.tgt = HBRR_TGT_CFG;
                end
                else if (hbrr_in_win(gfx_io_win_in, s_q.h_addr))
                begin
                    s_d.route.tgt = HBRR_TGT_GFX;
                end
                else
                begin
                    s_d.route.tgt = HBRR_TGT_HUB;
                end
            end
            else if (aper_hit)
            begin
                s_d.route.tgt = HBRR_TGT_DRAM;
                s_d.route.addr = xlat_addr;
            end
            else if (hbrr_in_win(gfx_mem_win_in, s_q.h_addr))
            begin
                s_d.route.tgt = HBRR_TGT_GFX;
            end
            else if (s_q.h_addr < dram_top_in)
            begin
                s_d.route.tgt = HBRR_TGT_DRAM;
            end
            else
            begin
                s_d.route.tgt = HBRR_TGT_HUB;
            end
            pl = hbrr_pg_loc(s_d.route.addr);
            s_d.page_hit = (s_d.route.tgt == HBRR_TGT_DRAM) && s_q.pg_vld[pl.rank][pl.bank]
                && (s_q.pg_row[pl.rank][pl.bank] == pl.row);
        end

        // host strobe is active low; address levels are complemented
        if (!s_q.h_pend && !cpu_ads_n_in)
        begin
            s_d.h_pend = 1'b1;
            s_d.h_io = cpu_io_in;
            s_d.h_wr = cpu_wr_in;
            s_d.h_addr = ~cpu_addr_n_in;
        end

        // inbound port requests
        for (int i = 0; i < HBRR_NASYNC; i++)
        begin
            if (arb_gnt[i+1])
            begin
                a = port_attr_in[i];
                s_d.ack[i] = 1'b1;
                s_d.fwd.src = 3'(i + 1);
                s_d.fwd.is_write = a.is_write;
                s_d.fwd.addr = a.addr;
                if (i + 1 == HBRR_P_HUB && a.to_gfx)
                begin
                    if (a.is_mem && a.is_write)
                    begin
                        s_d.fwd.valid = 1'b1;
                        s_d.fwd.tgt = HBRR_TGT_GFX;
                    end
                    else
                    begin
                        s_d.drop = 1'b1;
                    end
                end
                else
                begin
                    s_d.fwd.valid = 1'b1;
                    s_d.fwd.tgt = HBRR_TGT_DRAM;
                    s_d.snoop = !(i + 1 == HBRR_P_GFX && (a.agp_sem || a.noncache));
                    s_d.snoop_addr_n = ~a.addr;
                end
            end
        end

        // graphics queue occupancy
        if (arb_gnt[HBRR_P_GFX] && !(gfx_done_in && s_q.gfx_cnt != '0))
        begin
            s_d.gfx_cnt = s_q.gfx_cnt + QCW'(1);
        end
        else if (!arb_gnt[HBRR_P_GFX] && gfx_done_in && s_q.gfx_cnt != '0)
        begin
            s_d.gfx_cnt = s_q.gfx_cnt - QCW'(1);
        end

        // full flag kept in a flop so the output comes straight from one
        s_d.gfx_full = s_d.gfx_cnt >= QCW'(GFX_QDEPTH);

        s_d.ref_go = arb_gnt[HBRR_P_DRAM];

        // open page table, open wins over close on the same slot
        ol = hbrr_pg_loc(pg_addr_in);
        if (pg_close_in)
        begin
            s_d.pg_vld[ol.rank][ol.bank] = 1'b0;
        end
        if (pg_open_in)
        begin
            s_d.pg_vld[ol.rank][ol.bank] = 1'b1;
            s_d.pg_row[ol.rank][ol.bank] = ol.row;
        end
        for (int r = 0; r < HBRR_NRANK; r++)
        begin
            for (int b = 0; b < HBRR_NBANK; b++)
            begin
                cnt = cnt + OCW'(s_d.pg_vld[r][b]);
            end
        end
        s_d.open_cnt = cnt;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign host_busy_out = s_q.h_pend;
    assign port_ack_out = s_q.ack;
    assign gfx_qcnt_out = s_q.gfx_cnt;
    assign gfx_full_out = gfx_full;
    assign ref_go_out = s_q.ref_go;
    assign pipe_en_out = s_q.pipe_en;
    assign sba_en_out = s_q.sba_en;
    assign mode_err_out = s_q.mode_err;
    assign ratio_out = s_q.ratio;
    assign route_out = s_q.route;
    assign fwd_out = s_q.fwd;
    assign drop_out = s_q.drop;
    assign snoop_out = s_q.snoop;
    assign snoop_addr_n_out = s_q.snoop_addr_n;
    assign page_hit_out = s_q.page_hit;
    assign open_cnt_out = s_q.open_cnt;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_io_target:
        assert property (@(posedge clk_in) disable iff (!rst_n_in) route_out.valid && route_out.is_io
            |-> route_out.tgt inside {HBRR_TGT_GFX, HBRR_TGT_HUB, HBRR_TGT_CFG})
        else $error("io cycle routed to illegal target");

    a_mem_target:
        assert property (@(posedge clk_in) disable iff (!rst_n_in) route_out.valid && !route_out.is_io
            |-> route_out.tgt inside {HBRR_TGT_GFX, HBRR_TGT_HUB, HBRR_TGT_DRAM})
        else $error("memory cycle routed to illegal target");

    a_aper_remap:
        assert property (@(posedge clk_in) disable iff (!rst_n_in) arb_gnt[0] && !s_q.h_io && aper_hit
            |=> route_out.tgt == HBRR_TGT_DRAM && route_out.addr == $past(xlat_addr))
        else $error("aperture hit not translated");

    a_addr_invert:
        assert property (@(posedge clk_in) disable iff (!rst_n_in) !cpu_ads_n_in && !host_busy_out
            |=> host_busy_out && s_q.h_addr == ~$past(cpu_addr_n_in))
        else $error("host address not captured inverted");

    a_strobe_idle:
        assert property (@(posedge clk_in) disable iff (!rst_n_in) cpu_ads_n_in && !host_busy_out
            |=> !host_busy_out)
        else $error("cycle taken with strobe deasserted");

    a_nc_nosnoop:
        assert property (@(posedge clk_in) disable iff (!rst_n_in) arb_gnt[1] && port_attr_in[0].noncache
            |=> !snoop_out)
        else $error("non-cacheable graphics access snooped");

    a_hub_snoop:
        assert property (@(posedge clk_in) disable iff (!rst_n_in) arb_gnt[2] && !port_attr_in[2-1].to_gfx
            |=> snoop_out && snoop_addr_n_out == ~$past(port_attr_in[2-1].addr))
        else $error("hub dram access not snooped");

    a_agp_nosnoop:
        assert property (@(posedge clk_in) disable iff (!rst_n_in) arb_gnt[1] && port_attr_in[0].agp_sem
            |=> !snoop_out && fwd_out.valid)
        else $error("graphics semantic cycle snooped");

    a_peer_write:
        assert property (@(posedge clk_in) disable iff (!rst_n_in) fwd_out.valid && fwd_out.tgt == HBRR_TGT_GFX
            |-> fwd_out.is_write && fwd_out.src == 3'h2)
        else $error("illegal hub to graphics forward");

    a_mode_excl:
        assert property (@(posedge clk_in) disable iff (!rst_n_in) !(pipe_en_out && sba_en_out))
        else $error("both graphics request methods enabled");

    a_queue_bound:
        assert property (@(posedge clk_in) disable iff (!rst_n_in)
            gfx_qcnt_out <= QCW'(GFX_QDEPTH) and (gfx_full_out |-> !arb_gnt[1]))
        else $error("graphics queue overflow");

    a_ratio_latch:
        assert property (@(posedge clk_in) disable iff (!rst_n_in) $rose(s_q.init_done)
            |-> ratio_out == hbrr_ratio_f($past(s_q.st2[2:0])))
        else $error("clock ratio not latched from strap");

    a_ack_sync:
        assert property (@(posedge clk_in) disable iff (!rst_n_in) $rose(port_ack_out[0])
            |-> $past(s_q.ps2[0]) && $past(arb_gnt[1]))
        else $error("port acknowledged without synchronised request");

    a_page_count:
        assert property (@(posedge clk_in) disable iff (!rst_n_in) open_cnt_out <= OCW'(HBRR_MAX_OPEN))
        else $error("too many open pages");

    a_default_hub:
        assert property (@(posedge clk_in) disable iff (!rst_n_in) arb_gnt[0] && !s_q.h_io && !aper_hit
            && !hbrr_in_win(gfx_mem_win_in, s_q.h_addr) && s_q.h_addr >= dram_top_in
            |=> route_out.tgt == HBRR_TGT_HUB)
        else $error("unclaimed cycle not sent to hub");

endmodule

`default_nettype wire

// ==== hbrr_pkg.sv ====
// package: constants, types and helpers of the host bridge request router
`default_nettype none

package hbrr_pkg;

    // ****************************************************************
    // widths, sizes and timing
    // ****************************************************************
    localparam int HBRR_ADDR_W = 32;
    localparam int HBRR_NPORT = 5;
    localparam int HBRR_NASYNC = 3;
    localparam int HBRR_GFX_QDEPTH = 32;
    localparam int HBRR_NRANK = 4;
    localparam int HBRR_NBANK = 4;
    localparam int HBRR_MAX_OPEN = 16;
    localparam int HBRR_GTT_N = 16;
    localparam int HBRR_PG_SHIFT = 12;
    localparam int HBRR_GTT_PW = HBRR_ADDR_W - HBRR_PG_SHIFT;
    localparam int HBRR_BANK_LSB = 12;
    localparam int HBRR_RANK_LSB = 14;
    localparam int HBRR_ROW_LSB = 16;
    localparam int HBRR_ROW_W = 13;
    localparam logic [1:0] HBRR_STRAP_WAIT = 2'h3;

    // ****************************************************************
    // arbiter slots
    // ****************************************************************
    localparam int HBRR_P_HOST = 0;
    localparam int HBRR_P_GFX = 1;
    localparam int HBRR_P_HUB = 2;
    localparam int HBRR_P_NSP = 3;
    localparam int HBRR_P_DRAM = 4;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        HBRR_TGT_NONE,
        HBRR_TGT_GFX,
        HBRR_TGT_HUB,
        HBRR_TGT_CFG,
        HBRR_TGT_DRAM
    } hbrr_tgt_e;

    typedef enum logic [2:0] {
        HBRR_R_3_4,
        HBRR_R_1_1,
        HBRR_R_3_2,
        HBRR_R_4_5,
        HBRR_R_5_4
    } hbrr_ratio_e;

    typedef struct packed {
        logic [2:0] num;
        logic [2:0] den;
    } hbrr_ratio_s;

    typedef struct packed {
        logic [HBRR_ADDR_W-1:0] base;
        logic [HBRR_ADDR_W-1:0] limit;
    } hbrr_win_s;

    typedef struct packed {
        logic valid;
        hbrr_tgt_e tgt;
        logic is_io;
        logic is_write;
        logic [HBRR_ADDR_W-1:0] addr;
    } hbrr_route_s;

    typedef struct packed {
        logic is_mem;
        logic is_write;
        logic agp_sem;
        logic noncache;
        logic hi_pri;
        logic to_gfx;
        logic [HBRR_ADDR_W-1:0] addr;
    } hbrr_inb_s;

    typedef struct packed {
        logic valid;
        hbrr_tgt_e tgt;
        logic [2:0] src;
        logic is_write;
        logic [HBRR_ADDR_W-1:0] addr;
    } hbrr_fwd_s;

    typedef struct packed {
        logic [1:0] rank;
        logic [1:0] bank;
        logic [HBRR_ROW_W-1:0] row;
    } hbrr_pgloc_s;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic hbrr_in_win(hbrr_win_s w, logic [HBRR_ADDR_W-1:0] a);
        return (a >= w.base) && (a <= w.limit);
    endfunction

    function automatic hbrr_pgloc_s hbrr_pg_loc(logic [HBRR_ADDR_W-1:0] a);
        hbrr_pgloc_s l;
        l.rank = a[HBRR_RANK_LSB +: 2];
        l.bank = a[HBRR_BANK_LSB +: 2];
        l.row = a[HBRR_ROW_LSB +: HBRR_ROW_W];
        return l;
    endfunction

    // unknown strap codes fall back to 1/1
    function automatic hbrr_ratio_s hbrr_ratio_f(logic [2:0] sel);
        hbrr_ratio_s r;
        case (sel)
            HBRR_R_3_4: r = '{num: 3'h3, den: 3'h4};
            HBRR_R_3_2: r = '{num: 3'h3, den: 3'h2};
            HBRR_R_4_5: r = '{num: 3'h4, den: 3'h5};
            HBRR_R_5_4: r = '{num: 3'h5, den: 3'h4};
            default: r = '{num: 3'h1, den: 3'h1};
        endcase
        return r;
    endfunction

endpackage

`default_nettype wire

// ==== hbrr_arb.sv ====
// round-robin arbiter with a high-priority class and registered grant
`default_nettype none

module hbrr_arb #(
    parameter int N = 5
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [N-1:0] req_in,
    input wire logic [N-1:0] hp_in,
    output logic [N-1:0] gnt_out
);
    import hbrr_pkg::*;

    localparam int PW = $clog2(N);

    typedef struct packed {
        logic [N-1:0] gnt;
        logic [PW-1:0] ptr;
    } hbrr_arb_st_s;

    hbrr_arb_st_s s_q;
    hbrr_arb_st_s s_d;

    // first requester after the pointer
    function automatic logic [N-1:0] pick(logic [N-1:0] m, logic [PW-1:0] p);
        logic [N-1:0] g;
        int idx;
        g = '0;
        for (int k = N; k >= 1; k--)
        begin
            idx = (int'(p) + k) % N;
            if (m[idx])
            begin
                g = '0;
                g[idx] = 1'b1;
            end
        end
        return g;
    endfunction

    always_comb
    begin
        logic [N-1:0] hreq;
        hreq = req_in & hp_in;
        s_d = s_q;
        s_d.gnt = pick((hreq != '0) ? hreq : req_in, s_q.ptr);
        for (int i = 0; i < N; i++)
        begin
            if (s_d.gnt[i])
            begin
                s_d.ptr = PW'(i);
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign gnt_out = s_q.gnt;

    a_grant_onehot:
        assert property (@(posedge clk_in) disable iff (!rst_n_in) $onehot0(gnt_out))
        else $error("more than one grant");

    a_grant_cause:
        assert property (@(posedge clk_in) disable iff (!rst_n_in)
            gnt_out != '0 |-> ($past(req_in) & gnt_out) == gnt_out)
        else $error("grant without request");

endmodule

`default_nettype wire

// ==== hbrr_port_mdl.sv ====
// far-side requester on one async port, four-phase handshake
`default_nettype none
module hbrr_port_mdl (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic ack_in,
    output logic req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // request raised on go, dropped once acked
    // ****************************************************************
    initial req_out = 1'b0;
    always @(posedge clk_in)
    begin
        if (go_in && !req_out && !ack_in)
            req_out <= 1'b1;
        else if (ack_in)
            req_out <= 1'b0;
    end
endmodule
`default_nettype wire

// ==== hbrr_top_tb_top.sv ====
// testbench for the host bridge request router
`default_nettype none
module hbrr_top_tb_top import hbrr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // stimulus and checks
    // ****************************************************************
    logic clk_in = 0, rst_n_in = 0, ads_n = 1, io = 0, gwr = 0, pipe = 1, sba = 0, pen, sen, snoop, drop;
    logic wr = 0, gd = 0, rf = 0, po = 0, pc = 0, busy, me, full, rg, ph;
    logic [31:0] pa = '0, sa;
    logic [5:0] qc;
    logic [4:0] oc;
    hbrr_fwd_s fwd;
    logic [31:0] addr_n = '1;
    logic [3:0] gidx = 4'h1;
    logic [2:0] go = 0, req, ack;
    hbrr_inb_s [2:0] attr = '0;
    hbrr_route_s route;
    hbrr_ratio_s ratio;
    hbrr_win_s cw = '{32'h0000_0CF8, 32'h0000_0CFF}, gw = '{32'h0000_1000, 32'h0000_10FF};
    hbrr_win_s mw = '{32'hC000_0000, 32'hC0FF_FFFF}, aw = '{32'h8000_0000, 32'h8000_FFFF};
    int fails = 0, checks = 0;
    always #10 clk_in = ~clk_in;
    hbrr_top dut_u (.clk_in, .rst_n_in, .cpu_ads_n_in(ads_n), .cpu_addr_n_in(addr_n), .cpu_io_in(io),
        .cpu_wr_in(wr), .host_busy_out(busy), .cfg_io_win_in(cw), .gfx_io_win_in(gw), .gfx_mem_win_in(mw),
        .aper_win_in(aw), .dram_top_in(32'h4000_0000), .gtt_wr_in(gwr), .gtt_idx_in(gidx),
        .gtt_page_in(20'h1_2345), .port_req_in(req), .port_attr_in(attr), .port_ack_out(ack),
        .gfx_done_in(gd), .gfx_qcnt_out(qc), .gfx_full_out(full), .dram_ref_req_in(rf), .ref_go_out(rg),
        .strap_pipe_in(pipe), .strap_sba_in(sba), .strap_ratio_in(3'h0), .pipe_en_out(pen),
        .sba_en_out(sen), .mode_err_out(me), .ratio_out(ratio), .route_out(route), .fwd_out(fwd),
        .drop_out(drop), .snoop_out(snoop), .snoop_addr_n_out(sa), .pg_open_in(po), .pg_close_in(pc),
        .pg_addr_in(pa), .page_hit_out(ph), .open_cnt_out(oc));
    for (genvar g = 0; g < 3; g++)
    begin : g_port
        hbrr_port_mdl mdl_u (.clk_in, .go_in(go[g]), .ack_in(ack[g]), .req_out(req[g]));
    end
    task automatic check(input string n, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic host(input logic i, input logic [31:0] a, input hbrr_tgt_e t, input logic [31:0] x);
        int n;
        io = i;
        wr = ~wr;
        addr_n = ~a;
        ads_n = 1'b0;
        @(negedge clk_in);
        ads_n = 1'b1;
        check("busy", busy, 1'b1);
        n = 0;
        while (route.valid !== 1'b1 && n < 10)
        begin
            @(negedge clk_in);
            n++;
        end
        check("valid", route.valid, 1'b1);
        check("tgt", route.tgt, t);
        check("addr", route.addr, x);
        check("wr", route.is_write, wr);
        $display("host test done");
    endtask
    task automatic port(input int i, input logic [5:0] f, input logic sn, dr);
        logic s, d;
        logic [5:0] v;
        logic [31:0] x;
        s = 0;
        d = 0;
        v = 0;
        x = 0;
        attr[i] = {f, 32'h0000_2000};
        go[i] = 1'b1;
        @(negedge clk_in);
        go[i] = 1'b0;
        repeat (14)
        begin
            @(negedge clk_in);
            s |= snoop;
            d |= drop;
            if (snoop)
                x = ~sa;
            if (fwd.valid)
                v = {fwd.tgt, fwd.src};
        end
        check("snoop", s, sn);
        check("drop", d, dr);
        check("saddr", x, sn ? 32'h0000_2000 : 32'h0);
        check("fwd", v, dr ? 6'h0 : {f[0] ? HBRR_TGT_GFX : HBRR_TGT_DRAM, 3'(i + 1)});
        $display("port test done");
    endtask
    task automatic queue();
        repeat (29) port(0, 6'b101000, 0, 0);
        check("qfull", {full, qc}, 7'h60);
        gd = 1'b1;
        @(negedge clk_in);
        gd = 1'b0;
        check("qfull", {full, qc}, 7'h1f);
        $display("queue test done");
    endtask
    task automatic misc();
        rf = 1'b1;
        repeat (2) @(negedge clk_in);
        rf = 1'b0;
        check("refgo", rg, 1'b1);
        pa = 32'h0001_5000;
        po = 1'b1;
        @(negedge clk_in);
        po = 1'b0;
        check("refgo", rg, 1'b0);
        check("open", oc, 5'h1);
        host(0, 32'h0001_5ABC, HBRR_TGT_DRAM, 32'h0001_5ABC);
        check("hit", ph, 1'b1);
        pc = 1'b1;
        @(negedge clk_in);
        pc = 1'b0;
        check("open", oc, 5'h0);
        $display("misc test done");
    endtask
    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #200000;
        fails++;
        results();
    end
    initial
    begin
        repeat (2) @(negedge clk_in);
        rst_n_in = 1'b1;
        gwr = 1'b1;
        @(negedge clk_in);
        gwr = 1'b0;
        repeat (6) @(negedge clk_in);
        check("mode", {me, pen, sen}, 3'b010);
        check("ratio", ratio, 6'h1c);
        host(0, 32'h3FFF_FFFF, HBRR_TGT_DRAM, 32'h3FFF_FFFF);
        host(0, 32'h4000_0000, HBRR_TGT_HUB, 32'h4000_0000);
        host(0, 32'hC000_0010, HBRR_TGT_GFX, 32'hC000_0010);
        host(0, 32'h8000_1123, HBRR_TGT_DRAM, 32'h1234_5123);
        host(0, 32'hFFFF_FFF0, HBRR_TGT_HUB, 32'hFFFF_FFF0);
        host(1, 32'h0000_0CF8, HBRR_TGT_CFG, 32'h0000_0CF8);
        host(1, 32'h0000_10FF, HBRR_TGT_GFX, 32'h0000_10FF);
        host(1, 32'h0000_0080, HBRR_TGT_HUB, 32'h0000_0080);
        port(0, 6'b101000, 0, 0);
        port(0, 6'b100100, 0, 0);
        port(0, 6'b100000, 1, 0);
        port(1, 6'b110000, 1, 0);
        port(1, 6'b100001, 0, 1);
        port(1, 6'b110001, 0, 0);
        port(2, 6'b110000, 1, 0);
        queue();
        misc();
        results();
    end
endmodule
`default_nettype wire
